// ==== design/sms_ctl.sv ====
`timescale 1ns/1ps
module sms_ctl import sms_pkg::*; #(
	parameter bit ENA_TIED = 1'b0
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              ce,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	sms_link_if.ctl                link
);
	logic [ADDR_W-1:0] aw_ff;
	logic              aw_got_ff;
	logic [DATA_W-1:0] w_ff;
	logic [3:0]        ws_ff;
	logic              w_got_ff;
	logic              bvalid_ff;
	logic [1:0]        bresp_ff;
	logic              rvalid_ff;
	logic [DATA_W-1:0] rdata_ff;
	logic [1:0]        rresp_ff;
	logic              ena_ff;
	logic              auto_ff;
	logic [DATA_W-1:0] meta_ff;
	logic              on_ff;
	logic              off_ff;
	logic              snap_ff;
	logic              meta_we_ff;
	logic              do_wr;
	logic              cmd_wr;
	logic [DATA_W-1:0] cmd_bits;
	logic [DATA_W-1:0] stat;

	assign s_axi_awready = ce & ~aw_got_ff & ~bvalid_ff;
	assign s_axi_wready  = ce & ~w_got_ff & ~bvalid_ff;
	assign s_axi_arready = ce & ~rvalid_ff;
	assign do_wr  = aw_got_ff & w_got_ff & ~bvalid_ff;
	assign cmd_wr = do_wr & (aw_ff == REG_CMD);
	assign cmd_bits = sms_strb(ZERO_W, w_ff, ws_ff);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ff     <= '0;
			aw_got_ff <= 1'b0;
			w_ff      <= ZERO_W;
			ws_ff     <= 4'h0;
			w_got_ff  <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ff     <= s_axi_awaddr;
				aw_got_ff <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ff     <= s_axi_wdata;
				ws_ff    <= s_axi_wstrb;
				w_got_ff <= 1'b1;
			end
			if (do_wr) begin
				aw_got_ff <= 1'b0;
				w_got_ff  <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff  <= (aw_ff > REG_POWER) ? RESP_SLVERR : RESP_OKAY;
			end else if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// Command pulses last exactly one cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			on_ff      <= 1'b0;
			off_ff     <= 1'b0;
			snap_ff    <= 1'b0;
			meta_we_ff <= 1'b0;
			meta_ff    <= ZERO_W;
		end else if (ce) begin
			on_ff      <= cmd_wr & cmd_bits[CMD_ON];
			off_ff     <= cmd_wr & cmd_bits[CMD_OFF];
			snap_ff    <= cmd_wr & cmd_bits[CMD_SNAP];
			meta_we_ff <= do_wr & (aw_ff == REG_META);
			if (do_wr && aw_ff == REG_META) begin
				meta_ff <= sms_strb(meta_ff, w_ff, ws_ff);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ena_ff  <= 1'b0;
			auto_ff <= 1'b0;
		end else if (ce) begin
			if (auto_ff && link.snap_valid && link.demand && link.snap_kind == SK_ON) begin
				ena_ff <= 1'b1;
			end
			if (do_wr && aw_ff == REG_CTRL && ws_ff[0]) begin
				ena_ff  <= w_ff[CTRL_ENA];
				auto_ff <= w_ff[CTRL_AUTO];
			end
			if (cmd_wr && (cmd_bits[CMD_ON] || cmd_bits[CMD_OFF])) begin
				ena_ff <= 1'b0;
			end
		end
	end

	always_comb begin
		stat = ZERO_W;
		stat[STAT_VAL]  = link.snap_valid;
		stat[STAT_ERR]  = link.snap_error;
		stat[STAT_BUSY] = link.busy;
		stat[STAT_DEM]  = link.demand;
		stat[STAT_KIND +: 2] = link.snap_kind;
		stat[STAT_CODE +: 2] = link.snap_code;
		stat[STAT_ENA]  = link.external_switch_enable;
		stat[STAT_IO +: 4]   = link.snap_io;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= ZERO_W;
			rresp_ff  <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				rvalid_ff <= 1'b1;
				rresp_ff  <= (s_axi_araddr > REG_POWER) ? RESP_SLVERR : RESP_OKAY;
				unique case (s_axi_araddr)
					REG_CTRL:   rdata_ff <= {30'h0000_0000, auto_ff, ena_ff};
					REG_META:   rdata_ff <= meta_ff;
					REG_STAT:   rdata_ff <= stat;
					REG_ENERGY: rdata_ff <= link.snap_energy;
					REG_PAGE:   rdata_ff <= {16'h0000, link.snap_page};
					REG_TIME:   rdata_ff <= link.snap_time;
					REG_POWER:  rdata_ff <= link.snap_power;
					default:    rdata_ff <= ZERO_W;
				endcase
			end else if (rvalid_ff && s_axi_rready) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp  = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata  = rdata_ff;
	assign s_axi_rresp  = rresp_ff;
	assign link.cmd_on   = on_ff;
	assign link.cmd_off  = off_ff;
	assign link.cmd_snap = snap_ff;
	assign link.meta_we  = meta_we_ff;
	assign link.meta_data = meta_ff;
	assign link.external_switch_enable = ENA_TIED | ena_ff;
endmodule // sms_ctl

// ==== design/sms_device.sv ====
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module sms_device import sms_pkg::*; #(
	parameter int FB_CYC = FB_TIMEOUT_CYC,
	parameter int SG_CYC = SIGN_CYC,
	parameter int TS_CYC = TS_TICK_CYC
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              ce,
	sms_link_if.dev                link,
	input  wire logic              contactor_feedback_input,
	input  wire logic              energy_pulse,
	input  wire logic [DATA_W-1:0] meas_power,
	input  wire logic              switch_pin_i,
	output logic                   switch_pin_o,
	output logic                   switch_pin_oe_n
);
	sms_state_e        state_ff;
	sms_state_e        nxt_state;
	sms_kind_e         kind_ff;
	logic              demand_ff;
	logic              valid_ff;
	logic              error_ff;
	logic [1:0]        code_ff;
	logic [DATA_W-1:0] ref_ff;
	logic [DATA_W-1:0] energy_ff;
	logic [DATA_W-1:0] power_ff;
	logic [DATA_W-1:0] meta_ff;
	logic [DATA_W-1:0] snap_meta_ff;
	logic [DATA_W-1:0] ts_ff;
	logic [DATA_W-1:0] ts_pre_ff;
	logic [DATA_W-1:0] snap_ts_ff;
	logic [PAGE_W-1:0] page_ff;
	logic [3:0]        io_ff;
	logic              tmr_start;
	logic [TMR_W-1:0]  tmr_load;
	logic              tmr_done;
	logic              fb_open;
	logic              drive;
	logic              start_cmd;
	logic              snap_cmd;
	logic              idle;

	localparam logic [TMR_W-1:0]  FB_LOAD = TMR_W'(FB_CYC);
	localparam logic [TMR_W-1:0]  SG_LOAD = TMR_W'(SG_CYC);
	localparam logic [DATA_W-1:0] TS_LAST = DATA_W'(TS_CYC - 1);
	localparam logic [DATA_W-1:0] ONE_W   = DATA_W'(1);
	localparam logic [PAGE_W-1:0] ONE_P   = PAGE_W'(1);

	assign fb_open = (contactor_feedback_input == FB_OPEN_LVL);
	assign idle = (state_ff == ST_IDLE);
	assign start_cmd = idle & (link.cmd_on | link.cmd_off);
	assign snap_cmd = idle & link.cmd_snap & demand_ff & ~start_cmd;

	assign drive = demand_ff & link.external_switch_enable;
	assign switch_pin_o = PIN_LOW;
	assign switch_pin_oe_n = ~drive;

	sms_timer #(
		.W (TMR_W)
	) u_timer (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.start   (tmr_start),
		.load    (tmr_load),
		.done    (tmr_done)
	);

	always_comb begin
		nxt_state = state_ff;
		tmr_start = 1'b0;
		tmr_load  = FB_LOAD;
		unique case (state_ff)
			ST_IDLE: begin
				if (start_cmd) begin
					nxt_state = ST_OPEN;
					tmr_start = 1'b1;
				end else if (snap_cmd) begin
					nxt_state = ST_COLL;
				end
			end
			ST_OPEN: begin
				if (fb_open) begin
					nxt_state = ST_COLL;
				end else if (tmr_done) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_COLL: begin
				nxt_state = ST_SIGN;
				tmr_start = 1'b1;
				tmr_load  = SG_LOAD;
			end
			ST_SIGN: begin
				if (tmr_done) begin
					nxt_state = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= ST_IDLE;
		end else if (ce) begin
			state_ff <= nxt_state;
		end
	end

	// Turn-on beats turn-off if both arrive
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			kind_ff <= SK_NONE;
		end else if (ce) begin
			if (start_cmd) begin
				kind_ff <= link.cmd_on ? SK_ON : SK_OFF;
			end else if (snap_cmd) begin
				kind_ff <= SK_INTER;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			demand_ff <= 1'b0;
		end else if (ce) begin
			if (start_cmd) begin
				demand_ff <= 1'b0;
			end else if (state_ff == ST_COLL && kind_ff == SK_ON) begin
				demand_ff <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			valid_ff <= 1'b0;
			error_ff <= 1'b0;
			code_ff  <= ERR_NONE;
		end else if (ce) begin
			if (start_cmd || snap_cmd) begin
				valid_ff <= 1'b0;
				error_ff <= 1'b0;
				code_ff  <= ERR_NONE;
			end else if (state_ff == ST_OPEN && !fb_open && tmr_done) begin
				error_ff <= 1'b1;
				code_ff  <= ERR_FB_TMO;
			end else if (state_ff == ST_SIGN && tmr_done) begin
				valid_ff <= 1'b1;
			end
		end
	end

	// Reference counter, runs in all states except ST_COLL of a turn-on, where it clears
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ref_ff <= ZERO_W;
		end else if (ce) begin
			if (state_ff == ST_COLL && kind_ff == SK_ON) begin
				ref_ff <= ZERO_W;
			end else if (energy_pulse) begin
				ref_ff <= ref_ff + ONE_W;
			end
		end
	end

	// Free-running timestamp in ticks
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ts_pre_ff <= ZERO_W;
			ts_ff     <= ZERO_W;
		end else if (ce) begin
			if (ts_pre_ff >= TS_LAST) begin
				ts_pre_ff <= ZERO_W;
				ts_ff     <= ts_ff + ONE_W;
			end else begin
				ts_pre_ff <= ts_pre_ff + ONE_W;
			end
		end
	end

	// Metadata only accepted between sequences
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_ff <= ZERO_W;
		end else if (ce && idle && link.meta_we) begin
			meta_ff <= link.meta_data;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			energy_ff    <= ZERO_W;
			power_ff     <= ZERO_W;
			snap_meta_ff <= ZERO_W;
			snap_ts_ff   <= ZERO_W;
			io_ff        <= 4'h0;
		end else if (ce && state_ff == ST_COLL) begin
			energy_ff    <= (kind_ff == SK_ON) ? ZERO_W : ref_ff;
			power_ff     <= meas_power;
			snap_meta_ff <= meta_ff;
			snap_ts_ff   <= ts_ff;
			io_ff        <= {contactor_feedback_input, switch_pin_i,
				link.external_switch_enable, demand_ff};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			page_ff <= '0;
		end else if (ce && state_ff == ST_SIGN && tmr_done && kind_ff == SK_INTER) begin
			page_ff <= page_ff + ONE_P;
		end
	end

	assign link.snap_valid  = valid_ff;
	assign link.snap_error  = error_ff;
	assign link.snap_kind   = kind_ff;
	assign link.snap_code   = code_ff;
	assign link.snap_energy = energy_ff;
	assign link.snap_power  = power_ff;
	assign link.snap_meta   = snap_meta_ff;
	assign link.snap_time   = snap_ts_ff;
	assign link.snap_page   = page_ff;
	assign link.snap_io     = io_ff;
	assign link.busy        = ~idle;
	assign link.demand      = demand_ff;
endmodule // sms_device

// ==== design/sms_link_if.sv ====
`timescale 1ns/1ps
interface sms_link_if;
	import sms_pkg::*;
	logic              cmd_on;
	logic              cmd_off;
	logic              cmd_snap;
	logic              meta_we;
	logic [DATA_W-1:0] meta_data;
	logic              external_switch_enable;
	logic              snap_valid;
	logic              snap_error;
	sms_kind_e         snap_kind;
	logic [1:0]        snap_code;
	logic [DATA_W-1:0] snap_energy;
	logic [DATA_W-1:0] snap_power;
	logic [DATA_W-1:0] snap_meta;
	logic [DATA_W-1:0] snap_time;
	logic [PAGE_W-1:0] snap_page;
	logic [3:0]        snap_io;
	logic              busy;
	logic              demand;

	modport dev (
		input  cmd_on, cmd_off, cmd_snap, meta_we, meta_data, external_switch_enable,
		output snap_valid, snap_error, snap_kind, snap_code, snap_energy, snap_power,
		output snap_meta, snap_time, snap_page, snap_io, busy, demand
	);
	modport ctl (
		output cmd_on, cmd_off, cmd_snap, meta_we, meta_data, external_switch_enable,
		input  snap_valid, snap_error, snap_kind, snap_code, snap_energy, snap_power,
		input  snap_meta, snap_time, snap_page, snap_io, busy, demand
	);
endinterface // sms_link_if

// ==== design/sms_pkg.sv ====
// Contract
// - Turn-on: force switch off, check open
// - Then collect, enable demand, sign, release
// - Start snapshot from reset counter, zero
// - Turn-off: open, confirm, collect, sign
// - Feedback is NC aux; timely state
// - Feedback timeout half second, else invalid
// - Valid only if switching succeeded, else error
// - Drive is demand AND external enable
// - Closed contactor pulls pin low, else open
// - Controller holds enable high to permit closure
// - Enable path purely combinational, fast
// - Turn-off: open 2 s, sign 8 s
// - Turn-on: ground 9.7 s, sign 10 s
// - Sign at demand active, ignore enable
// - Early enable held off until collected
// - Late enable overridden by demand drop
// - Unused enable tied permanently high
// - Enable low before on; metadata first
// - Withdraw enable before turn-off command
// - Intermediate snapshots advance pagination counter
// - Controller switches load with enable
// - Status valid only after snapshot completes
package sms_pkg;
	localparam int CLK_HZ          = 50_000_000;
	localparam int MS_HZ           = 1000;
	localparam int FB_TIMEOUT_MS   = 500;
	localparam int SIGN_TIME_MS    = 150;
	localparam int TS_TICK_MS      = 1000;
	localparam int FB_TIMEOUT_CYC  = FB_TIMEOUT_MS * (CLK_HZ / MS_HZ);
	localparam int SIGN_CYC        = SIGN_TIME_MS * (CLK_HZ / MS_HZ);
	localparam int TS_TICK_CYC     = TS_TICK_MS * (CLK_HZ / MS_HZ);
	// Upper limits the sequence must meet
	localparam int ENA_OFF_MAX_MS  = 1;
	localparam int ENA_ON_MAX_MS   = 2;
	localparam int OFF_OPEN_MAX_MS = 2000;
	localparam int OFF_SIGN_MAX_MS = 8000;
	localparam int ON_GND_MAX_MS   = 9700;
	localparam int ON_SIGN_MAX_MS  = 10000;
	localparam int TMR_W           = 32;
	localparam int DATA_W          = 32;
	localparam int ADDR_W          = 8;
	localparam int PAGE_W          = 16;

	localparam logic FB_OPEN_LVL = 1'b1;
	localparam logic PIN_LOW     = 1'b0;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_OPEN = 4'h2,
		ST_COLL = 4'h4,
		ST_SIGN = 4'h8
	} sms_state_e;

	typedef enum logic [1:0] {
		SK_NONE  = 2'h0,
		SK_ON    = 2'h1,
		SK_OFF   = 2'h2,
		SK_INTER = 2'h3
	} sms_kind_e;

	localparam logic [1:0] ERR_NONE   = 2'h0;
	localparam logic [1:0] ERR_FB_TMO = 2'h1;

	localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] REG_CMD    = 8'h04;
	localparam logic [ADDR_W-1:0] REG_META   = 8'h08;
	localparam logic [ADDR_W-1:0] REG_STAT   = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_ENERGY = 8'h10;
	localparam logic [ADDR_W-1:0] REG_PAGE   = 8'h14;
	localparam logic [ADDR_W-1:0] REG_TIME   = 8'h18;
	localparam logic [ADDR_W-1:0] REG_POWER  = 8'h1C;

	localparam int CTRL_ENA  = 0;
	localparam int CTRL_AUTO = 1;
	localparam int CMD_ON    = 0;
	localparam int CMD_OFF   = 1;
	localparam int CMD_SNAP  = 2;
	localparam int STAT_VAL  = 0;
	localparam int STAT_ERR  = 1;
	localparam int STAT_BUSY = 2;
	localparam int STAT_DEM  = 3;
	localparam int STAT_KIND = 4;
	localparam int STAT_CODE = 6;
	localparam int STAT_ENA  = 8;
	localparam int STAT_IO   = 12;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [DATA_W-1:0] ZERO_W = 32'h0000_0000;

	function automatic logic [DATA_W-1:0] sms_strb(input logic [DATA_W-1:0] old,
			input logic [DATA_W-1:0] wd, input logic [3:0] st);
		logic [DATA_W-1:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction
endpackage

// ==== design/sms_timer.sv ====
`timescale 1ns/1ps
module sms_timer import sms_pkg::*; #(
	parameter int W = TMR_W
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         ce,
	input  wire logic         start,
	input  wire logic [W-1:0] load,
	output logic              done
);
	localparam logic [W-1:0] ONE = W'(1);
	logic [W-1:0] cnt_ff;
	logic         run_ff;
	logic         done_ff;

	// Restart overrides a running count
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_ff  <= '0;
			run_ff  <= 1'b0;
			done_ff <= 1'b0;
		end else if (ce) begin
			done_ff <= 1'b0;
			if (start) begin
				cnt_ff <= load;
				run_ff <= 1'b1;
			end else if (run_ff) begin
				if (cnt_ff <= ONE) begin
					run_ff  <= 1'b0;
					done_ff <= 1'b1;
				end else begin
					cnt_ff <= cnt_ff - ONE;
				end
			end
		end
	end

	assign done = done_ff;
endmodule // sms_timer

// ==== sim/sms_assertions.sv ====
`timescale 1ns/1ps
module sms_assertions import sms_pkg::*; #(
	parameter int FB_CYC = 20,
	parameter int SG_CYC = 10
) (
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic              cmd_on,
	input wire logic              cmd_off,
	input wire logic              cmd_snap,
	input wire logic              external_switch_enable,
	input wire logic              snap_valid,
	input wire logic              snap_error,
	input wire sms_kind_e         snap_kind,
	input wire logic [1:0]        snap_code,
	input wire logic [DATA_W-1:0] snap_energy,
	input wire logic              busy,
	input wire logic              demand,
	input wire logic              switch_pin_oe_n
);
	localparam int SG_HI   = SG_CYC + 4;
	localparam int BUSY_HI = FB_CYC + SG_CYC + 8;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_drive;
		switch_pin_oe_n == !(demand && external_switch_enable);
	endproperty
	a_drive: assert property (p_drive)
		else $error("contactor drive differs from demand and enable");

	property p_cmd_take;
		(cmd_on || cmd_off) && !busy |=> busy && !demand && !snap_valid && !snap_error;
	endproperty
	a_cmd_take: assert property (p_cmd_take)
		else $error("turn command not taken with demand dropped");

	property p_end_flag;
		$fell(busy) |-> snap_valid != snap_error;
	endproperty
	a_end_flag: assert property (p_end_flag)
		else $error("sequence ended without exactly one of valid and error");

	property p_err;
		snap_error |-> snap_code == ERR_FB_TMO && !snap_valid && !demand;
	endproperty
	a_err: assert property (p_err)
		else $error("error report inconsistent");

	property p_start_zero;
		$fell(busy) && snap_valid && snap_kind == SK_ON |-> snap_energy == ZERO_W && demand;
	endproperty
	a_start_zero: assert property (p_start_zero)
		else $error("turn-on snapshot not zero or demand inactive");

	property p_off;
		snap_valid && snap_kind == SK_OFF |-> !demand;
	endproperty
	a_off: assert property (p_off)
		else $error("demand active after turn-off");

	property p_dem_rise;
		$rose(demand) |-> busy && snap_kind == SK_ON && !snap_valid;
	endproperty
	a_dem_rise: assert property (p_dem_rise)
		else $error("demand rose outside turn-on signing");

	property p_sign_time;
		$rose(demand) |-> ##[SG_CYC:SG_HI] $fell(busy);
	endproperty
	a_sign_time: assert property (p_sign_time)
		else $error("signing after demand too slow");

	property p_busy_bound;
		$rose(busy) |-> ##[1:BUSY_HI] !busy;
	endproperty
	a_busy_bound: assert property (p_busy_bound)
		else $error("sequence exceeded feedback plus signing time");

	property p_snap;
		cmd_snap && !busy && demand && !cmd_on && !cmd_off |=> busy && snap_kind == SK_INTER;
	endproperty
	a_snap: assert property (p_snap)
		else $error("intermediate snapshot not started");

	property p_valid_idle;
		busy |-> !snap_valid;
	endproperty
	a_valid_idle: assert property (p_valid_idle)
		else $error("snapshot valid while still busy");
endmodule // sms_assertions

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
module tb_top import sms_pkg::*; ;
	localparam int FB_C = 20;
	localparam int SG_C = 10;
	localparam logic [31:0] ONE = 32'h0000_0001;
	logic              aclk = 1'b0;
	logic              aresetn;
	logic              ce;
	logic [ADDR_W-1:0] s_axi_awaddr;
	logic              s_axi_awvalid;
	logic              s_axi_awready;
	logic [DATA_W-1:0] s_axi_wdata;
	logic [3:0]        s_axi_wstrb;
	logic              s_axi_wvalid;
	logic              s_axi_wready;
	logic [1:0]        s_axi_bresp;
	logic              s_axi_bvalid;
	logic              s_axi_bready;
	logic [ADDR_W-1:0] s_axi_araddr;
	logic              s_axi_arvalid;
	logic              s_axi_arready;
	logic [DATA_W-1:0] s_axi_rdata;
	logic [1:0]        s_axi_rresp;
	logic              s_axi_rvalid;
	logic              s_axi_rready;
	logic              fb = 1'b1;
	logic              energy_pulse = 1'b0;
	logic [DATA_W-1:0] meas_power;
	logic              pin_i;
	logic              pin_o;
	logic              pin_oe_n;
	logic              stuck_closed;
	int                mismatches;
	int                checks_done;

	sms_link_if sms_link_if_i ();
	sms_ctl sms_ctl_i (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .link(sms_link_if_i.ctl));
	sms_device #(.FB_CYC(FB_C), .SG_CYC(SG_C), .TS_CYC(5)) sms_device_i (.aclk(aclk),
		.aresetn(aresetn), .ce(ce), .link(sms_link_if_i.dev), .contactor_feedback_input(fb),
		.energy_pulse(energy_pulse), .meas_power(meas_power), .switch_pin_i(pin_i),
		.switch_pin_o(pin_o), .switch_pin_oe_n(pin_oe_n));
	sms_assertions #(.FB_CYC(FB_C), .SG_CYC(SG_C)) sms_assertions_i (.aclk(aclk),
		.aresetn(aresetn), .cmd_on(sms_link_if_i.cmd_on), .cmd_off(sms_link_if_i.cmd_off),
		.cmd_snap(sms_link_if_i.cmd_snap),
		.external_switch_enable(sms_link_if_i.external_switch_enable),
		.snap_valid(sms_link_if_i.snap_valid), .snap_error(sms_link_if_i.snap_error),
		.snap_kind(sms_link_if_i.snap_kind), .snap_code(sms_link_if_i.snap_code),
		.snap_energy(sms_link_if_i.snap_energy), .busy(sms_link_if_i.busy),
		.demand(sms_link_if_i.demand), .switch_pin_oe_n(pin_oe_n));

	always #10 aclk = ~aclk;
	// Open contact floats to the pull-up
	assign pin_i = pin_oe_n ? 1'b1 : pin_o;
	// Contactor follows the pin; aux contact reads 1 when open
	always @(posedge aclk) begin
		fb <= stuck_closed ? 1'b0 : pin_i;
		energy_pulse <= ~energy_pulse;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, er, "write response");
		@(posedge aclk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(d & m, e, "register read");
	endtask

	// Catches a missed start as well as a hang
	task automatic wait_idle();
		int n;
		logic seen;
		n = 0;
		while (!sms_link_if_i.busy && n < 8) begin
			@(posedge aclk);
			n++;
		end
		seen = sms_link_if_i.busy;
		chk(seen, ONE, "sequence never started");
		while (sms_link_if_i.busy && n < 400) begin
			@(posedge aclk);
			n++;
		end
		chk(sms_link_if_i.busy, ZERO_W, "sequence still busy");
	endtask

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge aclk);
		mismatches++;
		$display("Error at %0t ns: watchdog expired", $time);
		wrap_up();
	end

	initial begin
		logic [31:0] d;
		logic [31:0] pg;
		logic [1:0]  r;
		mismatches = 0;
		checks_done = 0;
		aresetn = 1'b0;
		ce = 1'b1;
		s_axi_awaddr = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = ZERO_W;
		s_axi_wstrb = 4'hF;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 8'h00;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		meas_power = 32'h0000_1234;
		stuck_closed = 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_chk(REG_STAT, 32'h0000_01FF, ZERO_W);
		$display("Test reset done");
		// Enable raised while the contactor still reports closed
		stuck_closed <= 1'b1;
		wr(REG_CMD, ONE, RESP_OKAY);
		wr(REG_CTRL, ONE, RESP_OKAY);
		chk(sms_link_if_i.busy, ONE, "turn-on running");
		chk(pin_i, ONE, "pin held open");
		stuck_closed <= 1'b0;
		wait_idle();
		rd_chk(REG_STAT, 32'h0000_01FF, 32'h0000_0119);
		chk(pin_i, ZERO_W, "pin grounded");
		rd_chk(REG_ENERGY, 32'hFFFF_FFFF, ZERO_W);
		rd_chk(REG_POWER, 32'hFFFF_FFFF, 32'h0000_1234);
		$display("Test turn-on done");
		rd(REG_PAGE, pg, r);
		for (int i = 1; i <= 2; i++) begin
			wr(REG_CMD, 32'h0000_0004, RESP_OKAY);
			wait_idle();
			rd_chk(REG_PAGE, 32'h0000_FFFF, (pg + i) & 32'h0000_FFFF);
			rd_chk(REG_STAT, 32'h0000_00FF, 32'h0000_0039);
		end
		$display("Test intermediate done");
		wr(REG_CTRL, ZERO_W, RESP_OKAY);
		@(posedge aclk);
		chk(pin_i, ONE, "pin opened by enable");
		wr(REG_CTRL, ONE, RESP_OKAY);
		@(posedge aclk);
		chk(pin_i, ZERO_W, "pin grounded by enable");
		$display("Test enable path done");
		meas_power <= 32'h0000_5678;
		wr(REG_CMD, 32'h0000_0002, RESP_OKAY);
		wait_idle();
		rd_chk(REG_STAT, 32'h0000_01FF, 32'h0000_0021);
		rd_chk(REG_POWER, 32'hFFFF_FFFF, 32'h0000_5678);
		chk(pin_i, ONE, "pin open after turn-off");
		$display("Test turn-off done");
		// Second command lands while busy and must be ignored
		stuck_closed <= 1'b1;
		wr(REG_CMD, ONE, RESP_OKAY);
		wr(REG_CMD, 32'h0000_0002, RESP_OKAY);
		wait_idle();
		rd_chk(REG_STAT, 32'h0000_00FF, 32'h0000_0052);
		chk(pin_i, ONE, "pin open after timeout");
		stuck_closed <= 1'b0;
		wr(REG_META, 32'hA5A5_0001, RESP_OKAY);
		wr(REG_CMD, ONE, RESP_OKAY);
		wait_idle();
		rd_chk(REG_STAT, 32'h0000_F1FF, 32'h0000_C019);
		chk(sms_link_if_i.snap_meta, 32'hA5A5_0001, "snapshot metadata");
		chk(pin_i, ONE, "pin open without enable");
		// Auto-enable closes once the turn-on snapshot is valid
		wr(REG_CTRL, 32'h0000_0002, RESP_OKAY);
		rd_chk(REG_CTRL, 32'h0000_0003, 32'h0000_0003);
		chk(pin_i, ZERO_W, "pin grounded by auto enable");
		$display("Test timeout done");
		rd(8'h20, d, r);
		chk(d, ZERO_W, "unmapped read data");
		chk(r, RESP_SLVERR, "unmapped read response");
		wr(8'h20, ONE, RESP_SLVERR);
		rd_chk(REG_CMD, 32'hFFFF_FFFF, ZERO_W);
		$display("Test register bus done");
		wrap_up();
	end
endmodule // tb_top
